//--- core/acs_consts.vh
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH

// Clock period
`define ACS_CLK_NS          10
// Conversion time unit, 30.52 us
`define ACS_CONV_UNIT_NS    30520
// Accumulator update period, 0.5 s
`define ACS_ACC_PERIOD_MS   500

// Slot count and widths
`define ACS_SLOTS           8
`define ACS_SLOT_W          3
`define ACS_RES_W           16

// Control register fields
`define ACS_CTL_EN_BIT      7
`define ACS_CTL_RES_HI      6
`define ACS_CTL_RES_LO      4
`define ACS_CTL_REF_BIT     3
`define ACS_CTL_SEL_HI      2
`define ACS_CTL_SEL_LO      0
`define ACS_CTL_RESET       8'h00

// Result register fields
`define ACS_RES_SIGN_BIT    15
`define ACS_RES_MAG_HI      14
`define ACS_MAG_BITS        15
`define ACS_RES_MIN_BITS    8

// Input source codes
`define ACS_SRC_CURRENT     3'h0
`define ACS_SRC_INT_TEMP    3'h1
`define ACS_SRC_THERM       3'h2
`define ACS_SRC_PACK        3'h3
`define ACS_SRC_RSVD        3'h4
`define ACS_SRC_AUX         3'h5
`define ACS_SRC_OFFSET      3'h6

// Slot numbers
`define ACS_SLOT_CURRENT    3'h0
`define ACS_SLOT_LAST       3'h7

// Register port offsets
`define ACS_ADDR_W          5
`define ACS_OFF_CTRL        5'h00
`define ACS_OFF_STATUS      5'h08
`define ACS_OFF_CYCLES      5'h09
`define ACS_OFF_RESULT      5'h10

`endif

//--- core/acs_timer.v
`include "acs_consts.vh"

module acs_timer #(
    parameter W = 32
) (
    input  wire         mclk,
    input  wire         rst,
    input  wire         start,
    input  wire [W-1:0] load,
    output wire         busy,
    output reg          done
);

    reg [W-1:0] count_reg;
    reg         busy_reg;

    assign busy = busy_reg;

    // Counts load cycles after start, then pulses done
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_reg <= {W{1'b0}};
            busy_reg  <= 1'b0;
            done      <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count_reg <= load - {{(W-1){1'b0}}, 1'b1};
                busy_reg  <= 1'b1;
            end else if (busy_reg) begin
                if (count_reg == {W{1'b0}}) begin
                    busy_reg <= 1'b0;
                    done     <= 1'b1;
                end else begin
                    count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule

//--- core/acs_accum.v
`include "acs_consts.vh"

module acs_accum (
    input  wire        mclk,
    input  wire        rst,
    input  wire        tick,
    input  wire        accum_enable,
    input  wire [15:0] source,
    output reg  [31:0] charge_sum,
    output reg  [31:0] discharge_charge_sum,
    output reg  [31:0] charge_time_count,
    output reg  [31:0] discharge_time_count
);

    wire        sign = source[`ACS_RES_SIGN_BIT];
    wire [31:0] mag  = {17'h00000, source[`ACS_RES_MAG_HI:0]};

    // Sign selects charge or discharge pair
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            charge_sum           <= 32'h00000000;
            discharge_charge_sum <= 32'h00000000;
            charge_time_count    <= 32'h00000000;
            discharge_time_count <= 32'h00000000;
        end else if (tick && accum_enable) begin
            if (sign) begin
                discharge_charge_sum <= discharge_charge_sum + mag;
                discharge_time_count <= discharge_time_count + 32'h00000001;
            end else begin
                charge_sum        <= charge_sum + mag;
                charge_time_count <= charge_time_count + 32'h00000001;
            end
        end
    end

endmodule

//--- core/acs_seq.v
// Summary of operation
// - Slot control and result registers go through the serial bus register port; conv_enable and accum_enable are direct inputs.
// - While enabled and active, conversion cycles of eight slots run back to back.
// - Slots are visited in fixed order, each converted as its fields describe.
// - Enabled slots convert; disabled slots are skipped straight to the next slot.
// - Control byte: enable bit 7, resolution 6-4, reference bit 3, input 2-0.
// - Each slot's conversion lands in that slot's own 16-bit result register.
// - Input codes: current, int temp, thermistor, pack, reserved, aux, offset.
// - Magnitude resolution is eight plus the resolution code, 8 to 15 bits.
// - Conversion time is 30.52 us times two to the power resolution plus one.
// - Reference bit 0 is differential 170mV, 1 is single-ended 340mV.
// - Results are sign-magnitude: sign bit 15, magnitude bits 14 to 0.
// - Short results are left-aligned with zeros in unused low magnitude bits.
// - Slot inputs are not fixed: each slot converts whichever input code its own control byte selects.
// - Charge and discharge sums and time counts use only the slot 0 result.
// - Offset source shorts the converter input to ground for the conversion.
// - Thermistor current source is on only during external temperature conversions.
// - With accumulation enabled, sums add their source result every 0.5 seconds.
`include "acs_consts.vh"

module acs_seq #(
    parameter integer CONV_UNIT_CYCLES = `ACS_CONV_UNIT_NS / `ACS_CLK_NS,
    parameter integer ACC_TICK_CYCLES  = `ACS_ACC_PERIOD_MS * 100000 / `ACS_CLK_NS * 10
) (
    input  wire                   mclk,
    input  wire                   rst,
    input  wire [`ACS_ADDR_W-1:0] bus_addr,
    input  wire                   bus_wr_en,
    input  wire [7:0]             bus_wdata,
    input  wire                   bus_rd_en,
    output reg  [7:0]             bus_rdata,
    input  wire                   conv_enable,
    input  wire                   accum_enable,
    output reg                    adc_start,
    output reg                    adc_active,
    output reg  [2:0]             adc_input_sel,
    output reg                    adc_ref_sel,
    output reg  [2:0]             adc_res_code,
    output reg                    adc_short_gnd,
    output reg                    therm_src_en,
    input  wire                   adc_sign,
    input  wire [14:0]            adc_raw,
    output reg  [2:0]             cur_slot,
    output reg                    cycle_done,
    output reg  [15:0]            current_slot_result,
    output wire [31:0]            charge_sum,
    output wire [31:0]            discharge_charge_sum,
    output wire [31:0]            charge_time_count,
    output wire [31:0]            discharge_time_count
);

    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_SELECT = 2'h1;
    localparam [1:0] ST_CONV   = 2'h2;

    // Slot control and result storage
    reg  [7:0]  ctrl_reg   [0:`ACS_SLOTS-1];
    reg  [15:0] result_reg [0:`ACS_SLOTS-1];

    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [2:0]  slot_reg;
    reg  [2:0]  slot_next;
    reg  [15:0] cycles_reg;
    reg         conv_start;
    reg         result_we;
    reg         wrap;

    wire [7:0]  ctrl_cur  = ctrl_reg[slot_reg];
    wire        slot_en   = ctrl_cur[`ACS_CTL_EN_BIT];
    wire [2:0]  res_code  = ctrl_cur[`ACS_CTL_RES_HI:`ACS_CTL_RES_LO];
    wire        ref_bit   = ctrl_cur[`ACS_CTL_REF_BIT];
    wire [2:0]  sel_code  = ctrl_cur[`ACS_CTL_SEL_HI:`ACS_CTL_SEL_LO];

    wire        conv_busy;
    wire        conv_done;
    wire        tick_busy;
    wire        acc_tick;

    wire [31:0] conv_load;
    wire [4:0]  conv_shift;
    wire [3:0]  pad_bits;
    wire [14:0] mag_aligned;
    wire [15:0] result_word;
    wire [3:0]  res_bits;
    wire [3:0]  adc_bits;
    wire [31:0] tick_load;

    integer i;
    integer j;

    // Magnitude bits are eight plus the code
    assign res_bits   = 4'h8 + {1'b0, res_code};
    assign adc_bits   = 4'h8 + {1'b0, adc_res_code};

    // Cycles = unit * 2^(bits + 1)
    assign conv_shift = {1'b0, res_bits} + 5'h01;
    assign conv_load  = CONV_UNIT_CYCLES[31:0] << conv_shift;

    // Tick timer rests one cycle between runs, so load one less
    assign tick_load  = ACC_TICK_CYCLES[31:0] - 32'h00000001;

    // Left-align the raw magnitude
    assign pad_bits    = 4'hF - adc_bits;
    assign mag_aligned = adc_raw << pad_bits;
    assign result_word = {adc_sign, mag_aligned};

    // Register port address decode
    wire        hit_ctrl    = (bus_addr[4:3] == 2'h0);
    wire        hit_status  = (bus_addr == `ACS_OFF_STATUS);
    wire        hit_cycles  = (bus_addr == `ACS_OFF_CYCLES);
    wire        hit_result  = bus_addr[4];
    wire [2:0]  ctrl_index  = bus_addr[2:0];
    wire [2:0]  res_index   = bus_addr[3:1];
    wire        res_high    = bus_addr[0];
    wire [15:0] res_sel     = result_reg[res_index];
    wire [7:0]  status_byte = {conv_enable, accum_enable, 1'b0, conv_busy, 1'b0, slot_reg};
    reg  [7:0]  rdata_next;

    // Control register writes from the serial bus port
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (i = 0; i < `ACS_SLOTS; i = i + 1) begin
                ctrl_reg[i] <= `ACS_CTL_RESET;
            end
        end else if (bus_wr_en && hit_ctrl) begin
            ctrl_reg[ctrl_index] <= bus_wdata;
        end
    end

    // Read data select, unmapped addresses read zero
    always @* begin
        rdata_next = 8'h00;
        if (hit_ctrl) begin
            rdata_next = ctrl_reg[ctrl_index];
        end else if (hit_status) begin
            rdata_next = status_byte;
        end else if (hit_cycles) begin
            rdata_next = cycles_reg[7:0];
        end else if (hit_result) begin
            rdata_next = res_high ? res_sel[15:8] : res_sel[7:0];
        end
    end

    // Register read path, registered one cycle after strobe
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            bus_rdata <= 8'h00;
        end else if (bus_rd_en) begin
            bus_rdata <= rdata_next;
        end
    end

    // Slot sequencer
    always @* begin
        state_next = state_reg;
        slot_next  = slot_reg;
        conv_start = 1'b0;
        result_we  = 1'b0;
        wrap       = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (conv_enable) begin
                    state_next = ST_SELECT;
                    slot_next  = `ACS_SLOT_CURRENT;
                end
            end
            ST_SELECT: begin
                if (!conv_enable) begin
                    state_next = ST_IDLE;
                end else if (slot_en) begin
                    conv_start = 1'b1;
                    state_next = ST_CONV;
                end else begin
                    slot_next = slot_reg + 3'h1;
                    wrap      = (slot_reg == `ACS_SLOT_LAST);
                end
            end
            ST_CONV: begin
                if (conv_done) begin
                    result_we  = 1'b1;
                    slot_next  = slot_reg + 3'h1;
                    wrap       = (slot_reg == `ACS_SLOT_LAST);
                    state_next = conv_enable ? ST_SELECT : ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            slot_reg  <= 3'h0;
        end else begin
            state_reg <= state_next;
            slot_reg  <= slot_next;
        end
    end

    // Completed cycles counter
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cycles_reg <= 16'h0000;
            cycle_done <= 1'b0;
        end else begin
            cycle_done <= wrap;
            if (wrap) begin
                cycles_reg <= cycles_reg + 16'h0001;
            end
        end
    end

    // Result storage, written only on completion
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (j = 0; j < `ACS_SLOTS; j = j + 1) begin
                result_reg[j] <= 16'h0000;
            end
        end else if (result_we) begin
            result_reg[slot_reg] <= result_word;
        end
    end

    // Slot 0 result feeds the accumulators
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            current_slot_result <= 16'h0000;
        end else if (result_we && (slot_reg == `ACS_SLOT_CURRENT)) begin
            current_slot_result <= result_word;
        end
    end

    // Converter drive, held through the conversion
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            adc_start     <= 1'b0;
            adc_active    <= 1'b0;
            adc_input_sel <= 3'h0;
            adc_ref_sel   <= 1'b0;
            adc_res_code  <= 3'h0;
            adc_short_gnd <= 1'b0;
            therm_src_en  <= 1'b0;
            cur_slot      <= 3'h0;
        end else begin
            adc_start <= conv_start;
            cur_slot  <= slot_next;
            if (conv_start) begin
                adc_active    <= 1'b1;
                adc_input_sel <= sel_code;
                adc_ref_sel   <= ref_bit;
                adc_res_code  <= res_code;
                adc_short_gnd <= (sel_code == `ACS_SRC_OFFSET);
                therm_src_en  <= (sel_code == `ACS_SRC_THERM);
            end else if (conv_done) begin
                adc_active    <= 1'b0;
                adc_short_gnd <= 1'b0;
                therm_src_en  <= 1'b0;
            end
        end
    end

    // Conversion duration timer
    acs_timer #(
        .W (32)
    ) u_conv_timer (
        .mclk  (mclk),
        .rst   (rst),
        .start (conv_start),
        .load  (conv_load),
        .busy  (conv_busy),
        .done  (conv_done)
    );

    // Free-running half-second tick
    acs_timer #(
        .W (32)
    ) u_tick_timer (
        .mclk  (mclk),
        .rst   (rst),
        .start (!tick_busy),
        .load  (tick_load),
        .busy  (tick_busy),
        .done  (acc_tick)
    );

    // Charge and discharge sums and time counts
    acs_accum u_accum (
        .mclk                 (mclk),
        .rst                  (rst),
        .tick                 (acc_tick),
        .accum_enable         (accum_enable),
        .source               (current_slot_result),
        .charge_sum           (charge_sum),
        .discharge_charge_sum (discharge_charge_sum),
        .charge_time_count    (charge_time_count),
        .discharge_time_count (discharge_time_count)
    );

endmodule

//--- sim/acs_conv_model.sv
module acs_conv_model (
    input  wire logic       mclk,
    input  wire logic       adc_start,
    input  wire logic       adc_active,
    input  wire logic       adc_ref_sel,
    input  wire logic [2:0] adc_res_code,
    output logic            adc_sign,
    output logic [14:0]     adc_raw
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        hold_reg;
    wire  [15:0] mask = 16'hFFFF >> (4'h8 - {1'b0, adc_res_code});
    initial begin
        adc_sign = 1'b0;
        adc_raw  = 15'h2AAA;
        hold_reg = 1'b0;
    end
    // New sample per start, scrambled outside conversions except the cycle after one ends
    always @(posedge mclk) begin
        hold_reg <= adc_active;
        if (adc_start) begin
            adc_sign <= adc_ref_sel ? 1'b0 : 1'($urandom);
            adc_raw  <= 15'($urandom) & mask[14:0];
        end else if (!adc_active && !hold_reg) begin
            {adc_sign, adc_raw} <= ~{adc_sign, adc_raw};
        end
    end
endmodule

//--- sim/acs_seq_assertions.sv
module acs_seq_assertions #(
    parameter integer CONV_UNIT_CYCLES = 1,
    parameter integer ACC_TICK_CYCLES  = 50
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        conv_enable,
    input wire logic        adc_start,
    input wire logic        adc_active,
    input wire logic [2:0]  adc_input_sel,
    input wire logic        adc_ref_sel,
    input wire logic [2:0]  adc_res_code,
    input wire logic        adc_short_gnd,
    input wire logic        therm_src_en,
    input wire logic [2:0]  cur_slot,
    input wire logic        cycle_done,
    input wire logic [15:0] current_slot_result,
    input wire logic [31:0] charge_sum,
    input wire logic [31:0] discharge_charge_sum,
    input wire logic [31:0] charge_time_count,
    input wire logic [31:0] discharge_time_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] act_cnt_reg;
    logic [2:0]  code_reg;
    wire  [31:0] conv_len = CONV_UNIT_CYCLES << (code_reg + 9);
    wire  [14:0] cur_mag  = current_slot_result[14:0];
    wire         cur_sign = current_slot_result[15];
    // Conversion length counter
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            act_cnt_reg <= 32'h0;
            code_reg    <= 3'h0;
        end else begin
            act_cnt_reg <= adc_active ? act_cnt_reg + 32'h1 : 32'h0;
            if (adc_start)
                code_reg <= adc_res_code;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_therm_gate: assert property (therm_src_en == (adc_active && adc_input_sel == 3'h2))
        else $error("thermistor source mismatch");
    a_ground_short: assert property (adc_short_gnd == (adc_active && adc_input_sel == 3'h6))
        else $error("ground short mismatch");
    a_start_active: assert property (adc_start |-> adc_active)
        else $error("start without active");
    a_fields_hold: assert property (adc_active && $past(adc_active) |->
        $stable({adc_input_sel, adc_ref_sel, adc_res_code})) else $error("fields moved");
    a_conv_time: assert property (!adc_active && act_cnt_reg != 32'h0 |->
        act_cnt_reg >= conv_len && act_cnt_reg <= conv_len + 32'h3) else $error("bad length");
    a_idle_quiet: assert property (adc_start |-> $past(conv_enable))
        else $error("start while disabled");
    a_wrap_zero: assert property (cycle_done |-> cur_slot == 3'h0 && $past(cur_slot) == 3'h7)
        else $error("bad wrap");
    a_slot_step: assert property ($changed(cur_slot) && cur_slot != 3'h0 |->
        cur_slot == $past(cur_slot) + 3'h1) else $error("slot order broken");
    a_result_copy: assert property ($changed(current_slot_result) |->
        $fell(adc_active) && $past(cur_slot) == 3'h0) else $error("stray slot 0 write");
    a_charge_add: assert property ($changed(charge_time_count) |-> !$past(cur_sign) &&
        charge_sum == $past(charge_sum) + {17'h0, $past(cur_mag)}) else $error("charge sum");
    a_discharge_add: assert property ($changed(discharge_time_count) |-> $past(cur_sign) &&
        discharge_charge_sum == $past(discharge_charge_sum) + {17'h0, $past(cur_mag)})
        else $error("discharge sum");
endmodule

bind acs_seq acs_seq_assertions #(
    .CONV_UNIT_CYCLES(CONV_UNIT_CYCLES),
    .ACC_TICK_CYCLES (ACC_TICK_CYCLES)
) u_chk (.*);

//--- sim/acs_seq_bench.sv
module acs_seq_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam integer TICK = 50;
    logic        mclk, rst, bus_wr_en, bus_rd_en, conv_enable, accum_enable;
    logic        adc_start, adc_active, adc_ref_sel, adc_short_gnd, therm_src_en;
    logic        adc_sign, cycle_done, rd_pend, was_act, cap_sign, sgn;
    logic [2:0]  adc_input_sel, adc_res_code, cur_slot, cv_slot, cv_code;
    logic [4:0]  bus_addr;
    logic [7:0]  bus_wdata, bus_rdata, rd_q[$], ctl[8];
    logic [10:0] conv_q[$], note;
    logic [14:0] adc_raw, cap_raw;
    logic [15:0] current_slot_result, exp_res[8];
    logic [31:0] charge_sum, discharge_charge_sum, charge_time_count, discharge_time_count, tc;
    int          fail_count, checks_done, n;

    acs_seq #(.CONV_UNIT_CYCLES(1), .ACC_TICK_CYCLES(TICK)) dut (.*);
    acs_conv_model u_conv (.*);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic fail_msg(input string m);
        fail_count++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) fail_msg($sformatf("read %h want %h", g, e));
    endtask
    task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) fail_msg($sformatf("value %h want %h", g, e));
    endtask
    task automatic chk_conv(input logic [10:0] e);
        checks_done++;
        if ({cur_slot, adc_res_code, adc_ref_sel, adc_input_sel} !== {e[10:8], e[6:0]})
            fail_msg($sformatf("conversion setup wrong, slot %0d", e[10:8]));
    endtask
    task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk) #1;
        bus_addr = a;
        bus_wdata = d;
        bus_wr_en = 1'b1;
        @(posedge mclk) #1;
        bus_wr_en = 1'b0;
    endtask
    task automatic bus_rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge mclk) #1;
        bus_addr = a;
        bus_rd_en = 1'b1;
        rd_q.push_back(e);
        @(posedge mclk) #1;
        bus_rd_en = 1'b0;
    endtask
    task automatic rd_res(input logic [2:0] s);
        bus_rd({1'b1, s, 1'b0}, exp_res[s][7:0]);
        bus_rd({1'b1, s, 1'b1}, exp_res[s][15:8]);
    endtask
    task automatic run_until_slot(input logic [2:0] s);
        conv_enable = 1'b1;
        for (n = 0; n < 80000 && !(cur_slot === s && adc_active === 1'b1); n++) @(posedge mclk) #1;
        if (n >= 80000) fail_msg("slot wait limit");
        conv_enable = 1'b0;
        for (n = 0; n < 80000 && adc_active !== 1'b0; n++) @(posedge mclk) #1;
        if (n >= 80000) fail_msg("end wait limit");
        repeat (4) @(posedge mclk) #1;
        chk_val(conv_q.size(), 0);
        for (int s = 0; s < 8; s++) rd_res(s[2:0]);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Read data and conversion monitor
    always @(posedge mclk) rd_pend <= bus_rd_en;
    always @(negedge mclk) begin
        if (rd_pend === 1'b1) begin
            if (rd_q.size() == 0) fail_msg("read without note");
            else chk_byte(bus_rdata, rd_q.pop_front());
        end
        if (adc_start === 1'b1) begin
            if (conv_q.size() == 0) fail_msg("conversion without note");
            else begin
                note = conv_q.pop_front();
                chk_conv(note);
                cv_slot = note[10:8];
                cv_code = note[6:4];
            end
        end
        if (adc_active === 1'b1) {cap_sign, cap_raw} = {adc_sign, adc_raw};
        if (was_act && adc_active === 1'b0) exp_res[cv_slot] = {cap_sign, cap_raw << (3'h7 - cv_code)};
        was_act = adc_active;
    end

    initial begin
        #950000;
        fail_msg("watchdog expired");
        give_verdict();
    end

    initial begin
        void'($urandom(32'h12B5B44C));
        {rst, bus_wr_en, bus_rd_en, conv_enable, accum_enable, was_act} = 6'h20;
        bus_addr = 5'h00;
        bus_wdata = 8'h00;
        for (int s = 0; s < 8; s++) exp_res[s] = 16'h0000;
        repeat (5) @(posedge mclk);
        #1 rst = 1'b0;
        bus_rd(5'h00, 8'h00);
        bus_rd(5'h13, 8'h00);
        ctl = '{8'h80, 8'h89, 8'h9A, 8'h8B, 8'h84, 8'h0D, 8'h86, 8'hAD};
        for (int s = 0; s < 8; s++) bus_wr(s[4:0], ctl[s]);
        bus_wr(5'h0C, 8'h5A);
        bus_wr(5'h12, 8'hFF);
        for (int s = 0; s < 8; s++) bus_rd(s[4:0], ctl[s]);
        bus_rd(5'h0C, 8'h00);
        bus_rd(5'h12, 8'h00);
        for (int p = 0; p < 2; p++)
            for (int s = 0; s < 8; s++)
                if (ctl[s][7]) conv_q.push_back({s[2:0], ctl[s]});
        conv_enable = 1'b1;
        for (n = 0; n < 20000 && cycle_done !== 1'b1; n++) @(posedge mclk) #1;
        if (n >= 20000) fail_msg("cycle wait limit");
        for (n = 0; n < 9000 && cur_slot !== 3'h0; n++) @(posedge mclk) #1;
        if (n >= 9000) fail_msg("wrap wait limit");
        run_until_slot(3'h7);
        chk_val(current_slot_result, exp_res[0]);
        bus_rd(5'h09, 8'h02);
        accum_enable = 1'b1;
        bus_rd(5'h08, 8'h40);
        repeat (10 * TICK - 2) @(posedge mclk);
        #1 accum_enable = 1'b0;
        repeat (3) @(posedge mclk);
        #1 sgn = exp_res[0][15];
        tc = sgn ? discharge_time_count : charge_time_count;
        chk_val(sgn ? discharge_charge_sum : charge_sum, 32'h0000000A * exp_res[0][14:0]);
        chk_val(sgn ? charge_sum : discharge_charge_sum, 0);
        chk_val(tc, 32'h0000000A);
        for (int s = 0; s < 8; s++) bus_wr(s[4:0], s == 5 ? 8'hFD : ctl[s] & 8'h7F);
        conv_q.push_back({3'h5, 8'hFD});
        run_until_slot(3'h5);
        give_verdict();
    end
endmodule
